// ==== hw/wake_status_pkg.sv ====
// package: commands, field positions and state types for wake status and timer-2 gating
package wake_status_pkg;
    // command codes on the sequencer's instruction strobe
    typedef enum logic [3:0] {
        CMD_NONE          = 4'h0,
        CMD_SET_T2_OPT    = 4'h1,
        CMD_CLR_T2_OPT    = 4'h2,
        CMD_SET_FLAG      = 4'h3,
        CMD_CLR_FLAG      = 4'h4,
        CMD_CLEAR_REQ     = 4'h5,
        CMD_SET_WAKE_EN   = 4'h6,
        CMD_PORT_CHG_EN   = 4'h7,
        CMD_WRITE_STATUS1 = 4'h8,
        CMD_LOAD_TIMER2   = 4'h9,
        CMD_HALT          = 4'ha
    } cmd_t;

    typedef struct packed {
        cmd_t       cmd;
        logic [7:0] operand;
        logic [3:0] data;
    } cmd_bus_t;

    // wake source index into request / enable vectors
    localparam int SRC_T1     = 0;
    localparam int SRC_PIN    = 1;
    localparam int SRC_PREDIV = 2;
    localparam int SRC_T2     = 3;
    localparam int SRC_KEY    = 4;
    localparam int SRC_CONV   = 5;
    localparam int NUM_SRC    = 6;

    localparam logic [7:0] OPT_RELOAD    = 8'h01;
    localparam logic [7:0] OPT_GATE_HOLD = 8'h02;
    localparam logic [7:0] FLAG_CARRY    = 8'h01;
    localparam logic [7:0] FLAG_BACKUP   = 8'h02;

    // field positions in the status nibbles
    localparam int ST1_CARRY = 3;
    localparam int ST1_ZERO  = 2;
    localparam int ST2_PORTD = 3;
    localparam int ST2_GROUP = 2;
    localparam int ST2_PORTC = 1;
    localparam int ST2_BACK  = 0;
    localparam int ST3_PDIV  = 3;
    localparam int ST3_PH15  = 2;
    localparam int ST3_T1    = 1;
    localparam int ST3_PIN   = 0;
    localparam int STX_CONV  = 3;
    localparam int STX_T2    = 2;
    localparam int STX_KEY   = 1;

    localparam logic [5:0] T2_RELOAD_VALUE = 6'h3f;

    typedef enum logic [1:0] {
        CPU_RUN  = 2'b00,
        CPU_HALT = 2'b01
    } cpu_state_t;

    typedef struct packed {
        cpu_state_t           cpu_state;
        logic                 carry;
        logic                 backup;
        logic                 reload_en;
        logic                 gate_hold;
        logic                 gate;
        logic                 portc_en;
        logic                 portd_en;
        logic                 portc_flag;
        logic                 portd_flag;
        logic [NUM_SRC-1:0]   req;
        logic [NUM_SRC-1:0]   wen;
        logic [3:0]           key_prev;
        logic [3:0]           st1;
        logic [3:0]           st2;
        logic [3:0]           st3;
        logic [3:0]           stx;
        logic                 t2_reload;
        logic [NUM_SRC-1:0]   wake_flags;
    } state_t;
endpackage : wake_status_pkg

// ==== hw/wake_status_core.sv ====
// wake-cause flags, status nibbles, halt control and timer-2 converter gate
//
// Function
// - option set/clear 1 toggles timer-2 re-load
// - re-load restarts timer-2 from all ones
// - timer-2 load sets gate, underflow clears
// - gate-hold keeps gate across underflow
// - hold cleared, final underflow drops gate
// - carry flag bit 3, readable and writable
// - zero flag bit 2 follows accumulator
// - status1 readable and writable from memory
// - status2 layout: portd, group, portc, backup
// - port-c wake sets flag, enable clears
// - port-d wake sets flag, enable clears
// - grouped flag is live OR of all sources but key
// - halt refused while any start flag set
// - backup flag set/cleared by flag commands
// - interrupt pin wake request and flag
// - first timer underflow wake request and flag
// - pre-divider overflow wake request and flag
// - status3 layout: prediv, stage15, t1, pin
// - status3 and extension show wake cause
// - second timer underflow sets its flag
`timescale 1ns/1ps
`default_nettype none
module wake_status_core
    import wake_status_pkg::*;
(
    input  wire logic                        I_CLK,
    input  wire logic                        I_RESETN,
    input  wire wake_status_pkg::cmd_bus_t   i_cmd,
    input  wire logic                        i_carry_valid,
    input  wire logic                        i_carry_in,
    input  wire logic [3:0]                  i_acc,
    input  wire logic                        i_portc_change,
    input  wire logic                        i_portd_change,
    input  wire logic                        i_pin_change,
    input  wire logic                        i_t1_underflow,
    input  wire logic                        i_t2_underflow,
    input  wire logic                        i_prediv_overflow,
    input  wire logic                        i_prediv_stage15,
    input  wire logic                        i_conv_finish,
    input  wire logic [3:0]                  i_key_input_lines,
    input  wire logic                        i_led_mode,
    output logic                             o_halted,
    output logic                             o_conv_count_gate,
    output logic                             o_t2_reload,
    output logic [3:0]                       o_status1,
    output logic [3:0]                       o_status2,
    output logic [3:0]                       o_status3,
    output logic [3:0]                       o_status_ext
);
    import wake_status_pkg::*;

    state_t s_reg;
    state_t s_next;

    // a key counts when any line sits at the active level for the display mode
    function automatic logic key_active(input logic [3:0] k, input logic led);
        key_active = led ? (|k) : ~(&k);
    endfunction : key_active

    function automatic logic opt_is(input cmd_bus_t c, input cmd_t op, input logic [7:0] v);
        opt_is = (c.cmd == op) && (c.operand == v);
    endfunction : opt_is

    logic [NUM_SRC-1:0] event_in;
    logic [NUM_SRC-1:0] flags;
    logic               grouped;
    logic               key_now;
    logic               key_was;

    always_comb begin
        key_now = key_active(i_key_input_lines, i_led_mode);
        key_was = key_active(s_reg.key_prev, i_led_mode);
        event_in = '0;
        event_in[SRC_T1]     = i_t1_underflow;
        event_in[SRC_PIN]    = i_pin_change;
        event_in[SRC_PREDIV] = i_prediv_overflow;
        event_in[SRC_T2]     = i_t2_underflow;
        event_in[SRC_KEY]    = key_now & ~key_was;
        event_in[SRC_CONV]   = i_conv_finish;

        s_next = s_reg;
        s_next.key_prev = i_key_input_lines;

        // a request cleared in the same cycle as a new event stays set
        for (int i = 0; i < NUM_SRC; i++) begin
            if (i_cmd.cmd == CMD_CLEAR_REQ && i_cmd.operand[i]) begin
                s_next.req[i] = 1'b0;
            end
            if (event_in[i]) begin
                s_next.req[i] = 1'b1;
            end
        end
        if (i_cmd.cmd == CMD_SET_WAKE_EN) begin
            s_next.wen = i_cmd.operand[NUM_SRC-1:0];
        end

        if (opt_is(i_cmd, CMD_SET_T2_OPT, OPT_RELOAD)) begin
            s_next.reload_en = 1'b1;
        end
        if (opt_is(i_cmd, CMD_CLR_T2_OPT, OPT_RELOAD)) begin
            s_next.reload_en = 1'b0;
        end
        if (opt_is(i_cmd, CMD_SET_T2_OPT, OPT_GATE_HOLD)) begin
            s_next.gate_hold = 1'b1;
        end
        if (opt_is(i_cmd, CMD_CLR_T2_OPT, OPT_GATE_HOLD)) begin
            s_next.gate_hold = 1'b0;
        end
        // a combined operand 3h sets both options in one command
        if (i_cmd.cmd == CMD_SET_T2_OPT && i_cmd.operand == (OPT_RELOAD | OPT_GATE_HOLD)) begin
            s_next.reload_en = 1'b1;
            s_next.gate_hold = 1'b1;
        end

        if (i_t2_underflow && !s_reg.gate_hold) begin
            s_next.gate = 1'b0;
        end
        if (i_cmd.cmd == CMD_LOAD_TIMER2) begin
            s_next.gate = 1'b1;
        end
        // this pulse is high the cycle after an underflow seen with re-load on; o_t2_reload carries reload_en, not this pulse
        s_next.t2_reload = i_t2_underflow & s_reg.reload_en;

        if (opt_is(i_cmd, CMD_SET_FLAG, FLAG_CARRY)) begin
            s_next.carry = 1'b1;
        end
        if (opt_is(i_cmd, CMD_CLR_FLAG, FLAG_CARRY)) begin
            s_next.carry = 1'b0;
        end
        if (i_carry_valid) begin
            s_next.carry = i_carry_in;
        end
        if (i_cmd.cmd == CMD_WRITE_STATUS1) begin
            s_next.carry = i_cmd.data[ST1_CARRY];
        end
        if (opt_is(i_cmd, CMD_SET_FLAG, FLAG_BACKUP)) begin
            s_next.backup = 1'b1;
        end
        if (opt_is(i_cmd, CMD_CLR_FLAG, FLAG_BACKUP)) begin
            s_next.backup = 1'b0;
        end

        if (i_cmd.cmd == CMD_PORT_CHG_EN) begin
            s_next.portc_en   = i_cmd.operand[1];
            s_next.portd_en   = i_cmd.operand[0];
            s_next.portc_flag = 1'b0;
            s_next.portd_flag = 1'b0;
        end
        if (s_reg.cpu_state == CPU_HALT && s_reg.portc_en && i_portc_change) begin
            s_next.portc_flag = 1'b1;
        end
        if (s_reg.cpu_state == CPU_HALT && s_reg.portd_en && i_portd_change) begin
            s_next.portd_flag = 1'b1;
        end

        // flags follow request and enable, so clearing either drops them
        flags = s_next.req & s_next.wen;
        s_next.wake_flags = flags;
        grouped = |(flags & ~(NUM_SRC'(1) << SRC_KEY));

        case (s_reg.cpu_state)
            CPU_RUN: begin
                // halt is ignored while any start flag stands
                if (i_cmd.cmd == CMD_HALT && !(|flags) && !s_next.portc_flag && !s_next.portd_flag) begin
                    s_next.cpu_state = CPU_HALT;
                end
            end
            CPU_HALT: begin
                if (|flags || s_next.portc_flag || s_next.portd_flag) begin
                    s_next.cpu_state = CPU_RUN;
                end
            end
            default: begin
                s_next.cpu_state = CPU_RUN;
            end
        endcase

        s_next.st1 = '0;
        s_next.st1[ST1_CARRY] = s_next.carry;
        s_next.st1[ST1_ZERO]  = (i_acc == 4'h0);
        s_next.st2 = '0;
        s_next.st2[ST2_PORTD] = s_next.portd_flag;
        s_next.st2[ST2_GROUP] = grouped | flags[SRC_CONV];
        s_next.st2[ST2_PORTC] = s_next.portc_flag;
        s_next.st2[ST2_BACK]  = s_next.backup;
        s_next.st3 = '0;
        s_next.st3[ST3_PDIV] = flags[SRC_PREDIV];
        s_next.st3[ST3_PH15] = i_prediv_stage15;
        s_next.st3[ST3_T1]   = flags[SRC_T1];
        s_next.st3[ST3_PIN]  = flags[SRC_PIN];
        s_next.stx = '0;
        s_next.stx[STX_CONV] = flags[SRC_CONV];
        s_next.stx[STX_T2]   = flags[SRC_T2];
        s_next.stx[STX_KEY]  = flags[SRC_KEY];
    end

    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // halt is the only state with bit 0 set, so no decode sits after the flop
    assign o_halted          = s_reg.cpu_state[0];
    assign o_conv_count_gate = s_reg.gate;
    assign o_t2_reload       = s_reg.reload_en;
    assign o_status1         = s_reg.st1;
    assign o_status2         = s_reg.st2;
    assign o_status3         = s_reg.st3;
    assign o_status_ext      = s_reg.stx;
endmodule : wake_status_core
`default_nettype wire

// ==== testbench/wake_src_model.sv ====
// sequencer and wake-source model: one-cycle command strobes and event pulses
`timescale 1ns/1ps
`default_nettype none
module wake_src_model
    import wake_status_pkg::*;
(
    input  wire logic                 clk,
    output wake_status_pkg::cmd_bus_t cmd,
    output logic [6:0]                ev
);
    // ev bits: 0 t1, 1 pin, 2 prediv, 3 t2, 4 port c, 5 port d, 6 conv
    initial begin
        cmd = '{CMD_NONE, 8'h00, 4'h0};
        ev = 7'h00;
    end
    task automatic issue(input cmd_t c, input logic [7:0] op, input logic [3:0] d);
        @(negedge clk);
        cmd = '{c, op, d};
        @(negedge clk);
        cmd = '{CMD_NONE, 8'h00, 4'h0};
    endtask : issue
    task automatic fire(input int idx);
        @(negedge clk);
        ev[idx] = 1'b1;
        @(negedge clk);
        ev = 7'h00;
    endtask : fire
endmodule : wake_src_model
`default_nettype wire

// ==== testbench/wake_status_core_assertions.sv ====
// checker: port-level properties of the wake status block
`timescale 1ns/1ps
`default_nettype none
module wake_status_core_assertions
    import wake_status_pkg::*;
(
    input wire logic                      I_CLK,
    input wire logic                      I_RESETN,
    input wire wake_status_pkg::cmd_bus_t i_cmd,
    input wire logic [3:0]                i_acc,
    input wire logic                      i_t2_underflow,
    input wire logic                      o_halted,
    input wire logic                      o_conv_count_gate,
    input wire logic                      o_t2_reload,
    input wire logic [3:0]                o_status1,
    input wire logic [3:0]                o_status2,
    input wire logic [3:0]                o_status3,
    input wire logic [3:0]                o_status_ext
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    // gate-hold is not on the ports, so it is tracked from the option commands
    logic hold_reg;
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) hold_reg <= 1'b0;
        else if (i_cmd.cmd inside {CMD_SET_T2_OPT, CMD_CLR_T2_OPT} && i_cmd.operand[1])
            hold_reg <= (i_cmd.cmd == CMD_SET_T2_OPT);
    end
    a_reload_opt: assert property (i_cmd.cmd inside {CMD_SET_T2_OPT, CMD_CLR_T2_OPT} && i_cmd.operand[0]
        |=> o_t2_reload == ($past(i_cmd.cmd) == CMD_SET_T2_OPT)) else $error("reload option wrong");
    a_gate_load: assert property (i_cmd.cmd == CMD_LOAD_TIMER2 |=> o_conv_count_gate)
        else $error("gate not set by load");
    a_gate_drop: assert property (i_t2_underflow && !hold_reg && i_cmd.cmd != CMD_LOAD_TIMER2
        |=> !o_conv_count_gate) else $error("gate kept after underflow");
    a_gate_hold: assert property (i_t2_underflow && hold_reg && o_conv_count_gate |=> o_conv_count_gate)
        else $error("gate dropped under hold");
    a_zero_flag: assert property ($past(I_RESETN) |=> o_status1[ST1_ZERO] == ($past(i_acc) == 4'h0)
        && o_status1[1:0] == 2'b00) else $error("zero flag wrong");
    a_group_or: assert property (o_status2[ST2_GROUP] == (o_status3[ST3_PDIV] | o_status3[ST3_T1]
        | o_status3[ST3_PIN] | o_status_ext[STX_T2] | o_status_ext[STX_CONV])) else $error("group flag wrong");
    a_halt_refused: assert property (i_cmd.cmd == CMD_HALT && (o_status2[3:1] != 3'b000 || o_status_ext[STX_KEY])
        |=> !o_halted) else $error("halt taken with flag set");
    a_backup_cmd: assert property (i_cmd.cmd inside {CMD_SET_FLAG, CMD_CLR_FLAG} && i_cmd.operand == FLAG_BACKUP
        |=> o_status2[ST2_BACK] == ($past(i_cmd.cmd) == CMD_SET_FLAG)) else $error("backup flag wrong");
    a_carry_write: assert property (i_cmd.cmd == CMD_WRITE_STATUS1
        |=> o_status1[ST1_CARRY] == $past(i_cmd.data[3])) else $error("carry write lost");
    a_port_clear: assert property (i_cmd.cmd == CMD_PORT_CHG_EN |=> o_status2[3] == 1'b0 && !o_status2[1])
        else $error("port flags not cleared");
    c_hold: cover property (i_t2_underflow && hold_reg ##1 o_conv_count_gate);
    c_halt: cover property (i_cmd.cmd == CMD_HALT ##1 o_halted);
    c_group: cover property (o_status2[ST2_GROUP]);
endmodule : wake_status_core_assertions
bind wake_status_core wake_status_core_assertions chk (.I_CLK, .I_RESETN, .i_cmd, .i_acc, .i_t2_underflow,
    .o_halted, .o_conv_count_gate, .o_t2_reload, .o_status1, .o_status2, .o_status3, .o_status_ext);
`default_nettype wire

// ==== testbench/halt_wake_status_and_t2_gate_bench.sv ====
// bench: directed scenarios for the wake status block
`timescale 1ns/1ps
`default_nettype none
module halt_wake_status_and_t2_gate_bench;
    import wake_status_pkg::*;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] acc = 4'h1;
    logic [3:0] keys = 4'hf;
    logic       led = 1'b0;
    logic       ph15 = 1'b0;
    logic       cy_v = 1'b0;
    logic       cy_in = 1'b0;
    cmd_bus_t   cmd;
    logic [6:0] ev;
    logic       halted, gate, reload;
    logic [3:0] s1, s2, s3, sx;
    int         failures = 0;
    int         tests_run = 0;
    always #2.5 clk = ~clk;
    wake_src_model src (.clk(clk), .cmd(cmd), .ev(ev));
    wake_status_core uut (.I_CLK(clk), .I_RESETN(rst_n), .i_cmd(cmd), .i_carry_valid(cy_v), .i_carry_in(cy_in),
        .i_acc(acc), .i_portc_change(ev[4]), .i_portd_change(ev[5]), .i_pin_change(ev[1]), .i_t1_underflow(ev[0]),
        .i_t2_underflow(ev[3]), .i_prediv_overflow(ev[2]), .i_prediv_stage15(ph15), .i_conv_finish(ev[6]),
        .i_key_input_lines(keys), .i_led_mode(led), .o_halted(halted), .o_conv_count_gate(gate),
        .o_t2_reload(reload), .o_status1(s1), .o_status2(s2), .o_status3(s3), .o_status_ext(sx));
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic t_regs;
        acc = 4'h0;
        tick(1);
        chk("status1", s1, 4'h4);
        src.issue(CMD_WRITE_STATUS1, 8'h00, 4'h8);
        chk("status1", s1, 4'hc);
        cy_v = 1'b1;
        tick(1);
        cy_v = 1'b0;
        chk("status1", s1, 4'h4);
        src.issue(CMD_SET_FLAG, FLAG_CARRY, 4'h0);
        acc = 4'h5;
        ph15 = 1'b1;
        tick(1);
        chk("status1", s1, 4'h8);
        chk("status3", s3, 4'h4);
        ph15 = 1'b0;
        src.issue(CMD_CLR_FLAG, FLAG_CARRY, 4'h0);
        chk("status1", s1, 4'h0);
        src.issue(CMD_SET_FLAG, FLAG_BACKUP, 4'h0);
        chk("status2", s2, 4'h1);
        src.issue(CMD_CLR_FLAG, FLAG_BACKUP, 4'h0);
        chk("status2", s2, 4'h0);
        $display("done: status registers");
    endtask : t_regs
    task automatic t_wakes;
        int         evi[5] = '{0, 1, 2, 3, 6};
        int         enb[5] = '{0, 1, 2, 3, 5};
        int         pos[5] = '{1, 0, 3, 6, 7};
        logic [7:0] st;
        for (int i = 0; i < 5; i++) begin
            src.issue(CMD_SET_WAKE_EN, 8'h3f, 4'h0);
            src.fire(evi[i]);
            st = {sx, s3};
            chk("wake flag", 4'(st[pos[i]]), 4'h1);
            chk("status2", s2, 4'h4);
            src.issue(CMD_HALT, 8'h00, 4'h0);
            chk("halted", 4'(halted), 4'h0);
            // odd entries drop the flag through the enable, even ones through the request
            if (i % 2) src.issue(CMD_SET_WAKE_EN, 8'h3f ^ (8'h01 << enb[i]), 4'h0);
            else src.issue(CMD_CLEAR_REQ, 8'h01 << enb[i], 4'h0);
            st = {sx, s3};
            chk("wake flag", 4'(st[pos[i]]), 4'h0);
            chk("status2", s2, 4'h0);
            src.issue(CMD_CLEAR_REQ, 8'h3f, 4'h0);
        end
        $display("done: wake sources");
    endtask : t_wakes
    task automatic t_key;
        src.issue(CMD_SET_WAKE_EN, 8'h10, 4'h0);
        keys = 4'he;
        tick(1);
        chk("status ext", sx, 4'h2);
        src.issue(CMD_HALT, 8'h00, 4'h0);
        chk("halted", 4'(halted), 4'h0);
        src.issue(CMD_CLEAR_REQ, 8'h10, 4'h0);
        chk("status ext", sx, 4'h0);
        keys = 4'h0;
        tick(1);
        led = 1'b1;
        tick(1);
        keys = 4'h2;
        tick(1);
        chk("status ext", sx, 4'h2);
        src.issue(CMD_SET_WAKE_EN, 8'h00, 4'h0);
        chk("status ext", sx, 4'h0);
        src.issue(CMD_CLEAR_REQ, 8'h3f, 4'h0);
        $display("done: key wake");
    endtask : t_key
    task automatic t_port;
        src.issue(CMD_PORT_CHG_EN, 8'h03, 4'h0);
        src.issue(CMD_HALT, 8'h00, 4'h0);
        chk("halted", 4'(halted), 4'h1);
        src.fire(4);
        chk("status2", s2, 4'h2);
        chk("halted", 4'(halted), 4'h0);
        src.issue(CMD_PORT_CHG_EN, 8'h03, 4'h0);
        chk("status2", s2, 4'h0);
        src.issue(CMD_HALT, 8'h00, 4'h0);
        src.fire(5);
        chk("status2", s2, 4'h8);
        src.issue(CMD_PORT_CHG_EN, 8'h00, 4'h0);
        chk("status2", s2, 4'h0);
        $display("done: port wake");
    endtask : t_port
    task automatic t_gate;
        src.issue(CMD_SET_WAKE_EN, 8'h08, 4'h0);
        src.issue(CMD_SET_T2_OPT, OPT_RELOAD, 4'h0);
        chk("reload", 4'(reload), 4'h1);
        src.issue(CMD_LOAD_TIMER2, 8'h00, 4'h0);
        chk("gate", 4'(gate), 4'h1);
        src.fire(3);
        chk("gate", 4'(gate), 4'h0);
        chk("status ext", sx, 4'h4);
        src.issue(CMD_LOAD_TIMER2, 8'h00, 4'h0);
        // operand 3h turns on re-load and gate-hold in one command
        src.issue(CMD_SET_T2_OPT, OPT_RELOAD | OPT_GATE_HOLD, 4'h0);
        chk("reload", 4'(reload), 4'h1);
        for (int i = 0; i < 2; i++) begin
            src.issue(CMD_CLEAR_REQ, 8'h08, 4'h0);
            src.issue(CMD_HALT, 8'h00, 4'h0);
            chk("halted", 4'(halted), 4'h1);
            src.fire(3);
            chk("halted", 4'(halted), 4'h0);
            chk("gate", 4'(gate), 4'h1);
            chk("status ext", sx, 4'h4);
        end
        src.issue(CMD_CLEAR_REQ, 8'h08, 4'h0);
        src.issue(CMD_CLR_T2_OPT, OPT_GATE_HOLD, 4'h0);
        src.fire(3);
        chk("gate", 4'(gate), 4'h0);
        src.issue(CMD_CLR_T2_OPT, OPT_RELOAD, 4'h0);
        chk("reload", 4'(reload), 4'h0);
        $display("done: timer-2 gate");
    endtask : t_gate
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        tick(1);
        t_regs;
        t_wakes;
        t_key;
        t_port;
        t_gate;
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude;
    end
endmodule : halt_wake_status_and_t2_gate_bench
`default_nettype wire
